// ### rtl/sfr_bank1_pkg.sv
package sfr_bank1_pkg;

  // register indices (file address, bank 1 unless mirrored); byte address is four times this
  localparam logic [8:0] IDX_INDIRECT_ACCESS_PORT = 9'h080;
  localparam logic [8:0] IDX_TIMER_OPTION_CONFIG = 9'h081;
  localparam logic [8:0] IDX_PC_LOW_BYTE = 9'h082;
  localparam logic [8:0] IDX_CORE_STATUS_FLAGS = 9'h083;
  localparam logic [8:0] IDX_INDIRECT_POINTER = 9'h084;
  localparam logic [8:0] IDX_PORT_A_DIRECTION = 9'h085;
  localparam logic [8:0] IDX_PORT_B_DIRECTION = 9'h086;
  localparam logic [8:0] IDX_PORT_C_DIRECTION = 9'h087;
  localparam logic [8:0] IDX_PORT_D_DIRECTION = 9'h088;
  localparam logic [8:0] IDX_PORT_E_DIRECTION = 9'h089;
  localparam logic [8:0] IDX_PC_HIGH_LATCH = 9'h08A;
  localparam logic [8:0] IDX_INTERRUPT_CONTROL = 9'h08B;
  localparam logic [8:0] IDX_PERIPHERAL_IRQ_ENABLE_ONE = 9'h08C;
  localparam logic [8:0] IDX_PERIPHERAL_IRQ_ENABLE_TWO = 9'h08D;
  localparam logic [8:0] IDX_RESET_CAUSE_FLAGS = 9'h08E;
  localparam logic [8:0] IDX_TIMER2_PERIOD = 9'h092;
  localparam logic [8:0] IDX_SYNC_SERIAL_SLAVE_ADDRESS = 9'h093;
  localparam logic [8:0] IDX_SYNC_SERIAL_STATE = 9'h094;
  localparam logic [8:0] IDX_SERIAL_TRANSMIT_CONTROL = 9'h098;
  localparam logic [8:0] IDX_BAUD_RATE_DIVISOR = 9'h099;
  localparam logic [8:0] IDX_ANALOG_PIN_CONFIG = 9'h09F;

  // plain storage cells, held in tables below
  localparam int NCELL = 17;
  localparam int CELL_PORT_D = 5;
  localparam int CELL_PORT_E = 6;
  localparam int CELL_PC_HIGH = 7;
  localparam int CELL_POINTER = 1;

  localparam logic [NCELL-1:0][8:0] CELL_IDX = {
    IDX_ANALOG_PIN_CONFIG, IDX_BAUD_RATE_DIVISOR, IDX_SERIAL_TRANSMIT_CONTROL,
    IDX_SYNC_SERIAL_STATE, IDX_SYNC_SERIAL_SLAVE_ADDRESS, IDX_TIMER2_PERIOD,
    IDX_PERIPHERAL_IRQ_ENABLE_TWO, IDX_PERIPHERAL_IRQ_ENABLE_ONE, IDX_INTERRUPT_CONTROL,
    IDX_PC_HIGH_LATCH, IDX_PORT_E_DIRECTION, IDX_PORT_D_DIRECTION, IDX_PORT_C_DIRECTION,
    IDX_PORT_B_DIRECTION, IDX_PORT_A_DIRECTION, IDX_INDIRECT_POINTER, IDX_TIMER_OPTION_CONFIG};
  // value after power-on or brown-out reset
  localparam logic [NCELL-1:0][7:0] CELL_POR = {
    8'h00, 8'h00, 8'h02, 8'h00, 8'h00, 8'hFF, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h07, 8'hFF, 8'hFF, 8'hFF, 8'h3F, 8'h00, 8'hFF};
  // bits left unchanged by pin or watchdog reset
  localparam logic [NCELL-1:0][7:0] CELL_KEEP = {
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hFF, 8'h00};
  // bits software may write
  localparam logic [NCELL-1:0][7:0] CELL_WR = {
    8'h07, 8'hFF, 8'hF5, 8'hC0, 8'hFF, 8'hFF, 8'h01, 8'hFF, 8'hFF,
    8'h1F, 8'h37, 8'hFF, 8'hFF, 8'hFF, 8'h3F, 8'hFF, 8'hFF};
  // implemented bits; the rest read zero
  localparam logic [NCELL-1:0][7:0] CELL_IMPL = {
    8'h07, 8'hFF, 8'hF7, 8'hFF, 8'hFF, 8'hFF, 8'h01, 8'hFF, 8'hFF,
    8'h1F, 8'hF7, 8'hFF, 8'hFF, 8'hFF, 8'h3F, 8'hFF, 8'hFF};
  // cells reached from every bank
  localparam logic [NCELL-1:0] CELL_MIRROR = 17'h00182;

  // core status layout and reset values
  localparam logic [7:0] STATUS_POR = 8'h18;
  localparam logic [7:0] STATUS_WR = 8'hE7;
  localparam logic [7:0] STATUS_KEEP_WARM = 8'h07;
  localparam int STATUS_IRP = 7;
  localparam int STATUS_RP1 = 6;
  localparam int STATUS_RP0 = 5;
  localparam int STATUS_TO = 4;
  localparam int STATUS_PD = 3;

  // reset cause layout
  localparam int CAUSE_POR = 1;
  localparam int CAUSE_BROWNOUT = 0;
  // the strap synchroniser shows its level at the fourth edge; capture one edge later
  localparam logic [2:0] CAUSE_SETTLE = 3'h4;
  localparam logic [12:0] PC_RESET = 13'h0000;
  localparam logic [1:0] BANK_ONE = 2'h1;

endpackage

// ### rtl/level_sync3.sv
`timescale 1ns/1ps
// three-stage synchroniser; the output moves only when stages two and three agree
module level_sync3 #(
  parameter bit RST_VAL = 1'b0
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic raw_i,
  output logic level_o
);
  logic s1_q; // metastable stage, read only by s2_q
  logic s2_q;
  logic s3_q;

  // shift chain
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      s1_q <= RST_VAL;
      s2_q <= RST_VAL;
      s3_q <= RST_VAL;
    end else begin
      s1_q <= raw_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // accept a new level once two settled stages agree
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      level_o <= RST_VAL;
    end else if (s2_q == s3_q) begin
      level_o <= s3_q;
    end
  end
endmodule // level_sync3

// ### rtl/dual_reset_cell.sv
`timescale 1ns/1ps
// one byte register with a cold value and a warm value that keeps some bits
module dual_reset_cell #(
  parameter logic [7:0] POR_VAL = 8'h00,
  parameter logic [7:0] KEEP_MASK = 8'h00,
  parameter logic [7:0] WR_MASK = 8'hFF,
  parameter logic [7:0] IMPL_MASK = 8'hFF
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic warm_i,
  input wire logic we_i,
  input wire logic [7:0] wdata_i,
  output logic [7:0] q_o
);
  // cold reset loads first set, warm reset the second, write merges masked bits
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      q_o <= POR_VAL & IMPL_MASK; // RQ6
    end else if (warm_i) begin
      q_o <= ((q_o & KEEP_MASK) | (POR_VAL & ~KEEP_MASK)) & IMPL_MASK; // RQ6
    end else if (we_i) begin
      q_o <= ((q_o & ~WR_MASK) | (wdata_i & WR_MASK)) & IMPL_MASK; // RQ1
    end
  end
endmodule // dual_reset_cell

// ### rtl/sfr_bank1.sv
// Register access over APB is this design's own decision.
`timescale 1ns/1ps
// What this block does
// (RQ1) unimplemented addresses and bits read zero, ignore writes
// (RQ2) five-bit latch feeds program counter upper bits
// (RQ3) core registers decode identically from every bank
// (RQ4) small package drops port d/e direction
// (RQ5) software keeps parallel-slave enable/flag clear there
// (RQ6) cold and warm resets load different values
// (RQ7) reset cause flags set by cold reset and by software writes, never by warm reset
// (RQ8) indirect access port redirects through pointer
module sfr_bank1
  import sfr_bank1_pkg::*;
#(
  parameter bit SMALL_PACKAGE = 1'b0
) (
  input wire logic clk_i, // 100 MHz system clock
  input wire logic rst_i, // power-on / brown-out reset, async, active high
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [3:0] pstrb_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic external_reset_pin_n_i, // warm reset pin, active low, asynchronous
  input wire logic watchdog_reset_i, // watchdog timeout, asynchronous level
  input wire logic brownout_cause_i, // high when the cold reset came from brown-out
  output logic [8:0] ind_addr_o, // data memory address for indirect access
  output logic [7:0] ind_wdata_o,
  output logic ind_wr_o,
  output logic ind_rd_o,
  input wire logic [7:0] ind_rdata_i, // valid the cycle after ind_rd_o
  output logic [12:0] pc_o,
  output logic [7:0] status_o,
  output logic [1:0] reset_cause_o,
  output logic [NCELL*8-1:0] cfg_o
);

  // synchronised warm reset sources and brown-out cause strap
  logic pin_n_s;
  logic wdt_s;
  logic brownout_s;
  logic warm; // any warm reset held

  level_sync3 #(.RST_VAL(1'b1)) u_sync_pin (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .raw_i(external_reset_pin_n_i),
    .level_o(pin_n_s)
  );

  level_sync3 #(.RST_VAL(1'b0)) u_sync_wdt (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .raw_i(watchdog_reset_i),
    .level_o(wdt_s)
  );

  level_sync3 #(.RST_VAL(1'b0)) u_sync_brownout (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .raw_i(brownout_cause_i),
    .level_o(brownout_s)
  );

  assign warm = ~pin_n_s | wdt_s; // RQ6

  // apb phase tracking: every access takes one wait state
  logic ack_q; // high in the completing access cycle
  logic access; // first access cycle
  logic wr_en; // write takes effect at this edge
  logic [8:0] fidx; // file address from the byte address
  logic [1:0] bank;

  assign access = psel_i & penable_i & ~ack_q;
  assign wr_en = psel_i & penable_i & ack_q & pwrite_i & pstrb_i[0];
  assign fidx = paddr_i[10:2];
  assign bank = fidx[8:7];
  assign pready_o = psel_i & penable_i & ack_q;
  assign pslverr_o = 1'b0; // unmapped reads answer zero, not an error

  // wait-state flop; drops after the completing cycle
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= access;
    end
  end

  // address decode helpers
  function automatic logic hit_core(input logic [8:0] a, input logic [8:0] idx);
    // mirrored registers ignore the bank bits
    hit_core = (a[6:0] == idx[6:0]);
  endfunction

  logic bank1;
  assign bank1 = (bank == BANK_ONE);

  logic hit_indirect;
  logic hit_pc_low;
  logic hit_status;
  logic hit_cause;
  assign hit_indirect = hit_core(fidx, IDX_INDIRECT_ACCESS_PORT); // RQ3
  assign hit_pc_low = hit_core(fidx, IDX_PC_LOW_BYTE); // RQ3
  assign hit_status = hit_core(fidx, IDX_CORE_STATUS_FLAGS); // RQ3
  assign hit_cause = bank1 && (fidx == IDX_RESET_CAUSE_FLAGS);

  // storage cells and their decode
  logic [NCELL-1:0] cell_hit;
  logic [NCELL-1:0][7:0] cell_q;

  for (genvar g = 0; g < NCELL; g++) begin : g_cell
    // ports d and e direction vanish on the small package
    localparam bit PRESENT = !(SMALL_PACKAGE && (g == CELL_PORT_D || g == CELL_PORT_E));
    if (PRESENT) begin : g_on
      assign cell_hit[g] = CELL_MIRROR[g] ? hit_core(fidx, CELL_IDX[g]) // RQ3
                                          : (fidx == CELL_IDX[g]);
      dual_reset_cell #(
        .POR_VAL(CELL_POR[g]),
        .KEEP_MASK(CELL_KEEP[g]),
        .WR_MASK(CELL_WR[g]),
        .IMPL_MASK(CELL_IMPL[g])
      ) u_cell (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .warm_i(warm),
        .we_i(wr_en & cell_hit[g]),
        .wdata_i(pwdata_i[7:0]),
        .q_o(cell_q[g])
      );
    end else begin : g_off
      // absent register: never decodes, reads zero
      assign cell_hit[g] = 1'b0; // RQ4
      assign cell_q[g] = 8'h00; // RQ4
    end
  end

  assign cfg_o = cell_q;

  // core status: bank bits, timeout and power-down flags, alu flags
  logic [7:0] status_q;
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      status_q <= STATUS_POR; // RQ6
    end else if (warm) begin
      // alu flags kept, bank bits cleared, timeout tells watchdog from pin
      status_q <= status_q & STATUS_KEEP_WARM; // RQ6
      status_q[STATUS_TO] <= ~wdt_s; // RQ6
      status_q[STATUS_PD] <= 1'b1; // RQ6
    end else if (wr_en && hit_status) begin
      // timeout and power-down are read-only
      status_q <= (status_q & ~STATUS_WR) | (pwdata_i[7:0] & STATUS_WR);
    end
  end

  assign status_o = status_q;

  // program counter; the upper bits only load from the latch
  logic [12:0] pc_q;
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      pc_q <= PC_RESET;
    end else if (warm) begin
      pc_q <= PC_RESET;
    end else if (wr_en && hit_pc_low) begin
      // writing the low byte transfers the latch into the upper bits
      pc_q <= {cell_q[CELL_PC_HIGH][4:0], pwdata_i[7:0]}; // RQ2
    end
  end

  assign pc_o = pc_q;

  // reset cause: cleared by cold reset, sampled once the strap has settled
  logic [1:0] cause_q;
  logic [2:0] settle_q; // cycles since cold reset release
  logic settled_q; // cause already captured

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      settle_q <= 3'h0;
    end else if (settle_q != CAUSE_SETTLE) begin
      settle_q <= settle_q + 3'h1;
    end
  end

  // capture after the synchroniser has filled; warm resets never touch it
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cause_q <= 2'h0; // RQ7
      settled_q <= 1'b0;
    end else if (!settled_q && settle_q == CAUSE_SETTLE) begin
      // brown-out leaves the power-on flag set, power-on clears both
      cause_q[CAUSE_POR] <= brownout_s; // RQ7
      cause_q[CAUSE_BROWNOUT] <= 1'b0; // RQ7
      settled_q <= 1'b1;
    end else if (wr_en && hit_cause) begin
      // software sets the flags so the next cold reset shows up
      cause_q <= pwdata_i[1:0];
    end
  end

  assign reset_cause_o = cause_q;

  // indirect access: no storage, the pointer forms the address
  assign ind_addr_o = {status_q[STATUS_IRP], cell_q[CELL_POINTER]}; // RQ8
  assign ind_wdata_o = pwdata_i[7:0];
  assign ind_rd_o = psel_i & ~penable_i & ~pwrite_i & hit_indirect; // RQ8
  assign ind_wr_o = wr_en & hit_indirect; // RQ8

  // read mux; anything unmatched reads zero
  logic [7:0] rd_byte;
  always_comb begin
    rd_byte = 8'h00; // RQ1
    for (int i = 0; i < NCELL; i++) begin
      if (cell_hit[i]) begin
        rd_byte = cell_q[i];
      end
    end
    if (hit_pc_low) begin
      rd_byte = pc_q[7:0];
    end else if (hit_status) begin
      rd_byte = status_q;
    end else if (hit_cause) begin
      rd_byte = {6'h00, cause_q}; // RQ1
    end else if (hit_indirect) begin
      rd_byte = ind_rdata_i; // RQ8
    end
  end

  // read data registered in the first access cycle, held to completion
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      prdata_o <= 32'h00000000;
    end else if (access && !pwrite_i) begin
      prdata_o <= {24'h000000, rd_byte}; // RQ1
    end
  end

endmodule // sfr_bank1

// ### tb/sfr_bank1_asserts.sv
`timescale 1ns/1ps
// bus and core-output relations of the bank-one register file
module sfr_bank1_asserts
  import sfr_bank1_pkg::*;
#(
  parameter bit SMALL_PACKAGE = 1'b0
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [3:0] pstrb_i,
  input wire logic [31:0] prdata_o,
  input wire logic pready_o,
  input wire logic pslverr_o,
  input wire logic [8:0] ind_addr_o,
  input wire logic [7:0] ind_wdata_o,
  input wire logic ind_wr_o,
  input wire logic ind_rd_o,
  input wire logic [12:0] pc_o,
  input wire logic [7:0] status_o,
  input wire logic [NCELL*8-1:0] cfg_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // low seven bits of the file address; mirrored cells match on these alone
  logic [6:0] low7;
  assign low7 = paddr_i[8:2];
  // access phase completing at this edge
  sequence done_s; psel_i && penable_i && pready_o; endsequence
  sequence rd_done_s; done_s ##0 !pwrite_i; endsequence
  // only a write with the low byte strobe lands
  sequence wr_done_s; done_s ##0 pwrite_i && pstrb_i[0]; endsequence
  no_error_a: assert property (!pslverr_o)
    else $error("error response raised");
  upper_zero_a: assert property (rd_done_s |-> prdata_o[31:8] == 24'h000000)
    else $error("read data upper bits not zero");
  unmapped_zero_a: assert property (rd_done_s ##0 paddr_i[10:2] inside
    {[9'h08F:9'h091], [9'h095:9'h097], [9'h09A:9'h09E]} |-> prdata_o == 32'h0)
    else $error("unmapped read not zero");
  small_gone_a: assert property (rd_done_s ##0 SMALL_PACKAGE &&
    paddr_i[10:2] inside {9'h088, 9'h089} |-> prdata_o == 32'h0)
    else $error("absent port register read not zero");
  pc_load_a: assert property (wr_done_s ##0 low7 == 7'h02 |=>
    pc_o == {$past(cfg_o[60:56]), $past(pwdata_i[7:0])})
    else $error("program counter not loaded from latch and low byte");
  ind_addr_a: assert property (ind_addr_o == {status_o[7], cfg_o[15:8]})
    else $error("indirect address not bank bit and pointer");
  ind_read_a: assert property (psel_i && !penable_i && !pwrite_i && low7 == 7'h00
    |-> ind_rd_o)
    else $error("indirect read not issued");
  ind_write_a: assert property (wr_done_s ##0 low7 == 7'h00 |->
    ind_wr_o && ind_wdata_o == pwdata_i[7:0])
    else $error("indirect write not issued");
endmodule // sfr_bank1_asserts

bind sfr_bank1 sfr_bank1_asserts #(.SMALL_PACKAGE(SMALL_PACKAGE)) sfr_bank1_asserts_i (
  .clk_i(clk_i), .rst_i(rst_i), .psel_i(psel_i), .penable_i(penable_i),
  .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pstrb_i(pstrb_i),
  .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
  .ind_addr_o(ind_addr_o), .ind_wdata_o(ind_wdata_o), .ind_wr_o(ind_wr_o),
  .ind_rd_o(ind_rd_o), .pc_o(pc_o), .status_o(status_o), .cfg_o(cfg_o));

// ### tb/test_sfr_bank1.sv
`timescale 1ns/1ps
// register-level bench; the small-package copy shares the bus
module test_sfr_bank1;
  import sfr_bank1_pkg::*;
  logic clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic pin_n = 1'b1, wdog = 1'b0, brown = 1'b1, pready, pready_s, pslverr;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, prdata_s, got, got_s;
  logic [3:0] pstrb = 4'hF;
  logic [7:0] ind_rdata = 8'h00, status;
  logic [8:0] ind_addr;
  logic [1:0] cause;
  logic [12:0] pc;
  int err_count = 0, tests_run = 0, cyc = 0;
  // address, cold value, value after writing all ones (7F to 08C)
  logic [8:0] adr [20] = '{9'h081, 9'h083, 9'h084, 9'h085, 9'h086, 9'h087, 9'h088,
    9'h089, 9'h08A, 9'h08B, 9'h08C, 9'h08D, 9'h08E, 9'h08F, 9'h092, 9'h093, 9'h094,
    9'h098, 9'h099, 9'h09F};
  logic [7:0] cold [20] = '{8'hFF, 8'h18, 8'h00, 8'h3F, 8'hFF, 8'hFF, 8'hFF, 8'h07,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h02, 8'h00, 8'hFF, 8'h00, 8'h00, 8'h02, 8'h00, 8'h00};
  logic [7:0] full [20] = '{8'hFF, 8'hFF, 8'hFF, 8'h3F, 8'hFF, 8'hFF, 8'hFF, 8'h37,
    8'h1F, 8'hFF, 8'h7F, 8'h01, 8'h03, 8'h00, 8'hFF, 8'hFF, 8'hC0, 8'hF7, 8'hFF, 8'h07};

  sfr_bank1 sfr_bank1_i (.clk_i(clk), .rst_i(rst), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .pstrb_i(pstrb),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
    .external_reset_pin_n_i(pin_n), .watchdog_reset_i(wdog), .brownout_cause_i(brown),
    .ind_addr_o(ind_addr), .ind_wdata_o(), .ind_wr_o(), .ind_rd_o(),
    .ind_rdata_i(ind_rdata), .pc_o(pc), .status_o(status), .reset_cause_o(cause), .cfg_o());
  // small package: same stimulus, only read data observed
  sfr_bank1 #(.SMALL_PACKAGE(1'b1)) sfr_bank1_small_i (.clk_i(clk), .rst_i(rst),
    .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
    .pwdata_i(pwdata), .pstrb_i(pstrb), .prdata_o(prdata_s), .pready_o(pready_s),
    .pslverr_o(), .external_reset_pin_n_i(pin_n), .watchdog_reset_i(wdog),
    .brownout_cause_i(brown), .ind_addr_o(), .ind_wdata_o(), .ind_wr_o(),
    .ind_rd_o(), .ind_rdata_i(ind_rdata), .pc_o(), .status_o(), .reset_cause_o(),
    .cfg_o());

  initial forever #5 clk = ~clk;
  // hang guard: the whole run needs well under a thousand cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      err_count++;
      stop_test();
    end
  end

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  // one apb transfer; request held until pready is seen, data taken at that edge
  task automatic xfer(input logic [8:0] a, input logic w, input logic [7:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {1'b0, a, 2'b00};
    pwdata <= {24'h0, d};
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    // values read here are those standing at this rising edge
    while (pready !== 1'b1) @(posedge clk);
    got = prdata;
    // the small copy must answer at the same edge, or its data count as wrong
    got_s = (pready_s === 1'b1) ? prdata_s : 32'hFFFFFFFF;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdchk(input logic [8:0] a, input logic [7:0] e);
    xfer(a, 1'b0, 8'h00);
    chk($sformatf("reg %h", a), {24'h0, e}, got);
  endtask
  // walk the table on both variants; the small one lacks 088 and 089
  task automatic table_chk(input logic f);
    logic [7:0] e;
    foreach (adr[k]) begin
      e = f ? full[k] : cold[k];
      rdchk(adr[k], e);
      chk("small", (adr[k] inside {9'h088, 9'h089}) ? 32'h0 : {24'h0, e}, got_s);
    end
  endtask

  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    repeat (6) @(posedge clk);
    table_chk(1'b0);
    // parallel-slave enable kept clear: reserved on the small package
    foreach (adr[k]) xfer(adr[k], 1'b1, (adr[k] == 9'h08C) ? 8'h7F : 8'hFF);
    table_chk(1'b1);
    $display("test table done");
    xfer(9'h003, 1'b1, 8'hA5);
    rdchk(9'h183, 8'hBD);
    xfer(9'h104, 1'b1, 8'h40);
    rdchk(9'h084, 8'h40);
    xfer(9'h10A, 1'b1, 8'h0C);
    chk("pc idle", 32'h0, {19'h0, pc});
    xfer(9'h082, 1'b1, 8'h34);
    @(negedge clk);
    chk("pc", 32'h0C34, {19'h0, pc});
    xfer(9'h00A, 1'b1, 8'hF5);
    xfer(9'h182, 1'b1, 8'h77);
    @(negedge clk);
    chk("pc bank3", 32'h1577, {19'h0, pc});
    $display("test mirror_pc done");
    chk("ind addr", 32'h140, {23'h0, ind_addr});
    ind_rdata <= 8'hA5;
    rdchk(9'h080, 8'hA5);
    ind_rdata <= 8'h3C;
    rdchk(9'h180, 8'h3C);
    xfer(9'h080, 1'b1, 8'h5A);
    $display("test indirect done");
    xfer(9'h092, 1'b1, 8'h12);
    xfer(9'h08E, 1'b1, 8'h01);
    xfer(9'h083, 1'b1, 8'hFF);
    pin_n <= 1'b0;
    repeat (10) @(posedge clk);
    pin_n <= 1'b1;
    repeat (10) @(posedge clk);
    rdchk(9'h092, 8'hFF);
    rdchk(9'h084, 8'h40);
    rdchk(9'h08E, 8'h01);
    rdchk(9'h083, 8'h1F);
    rdchk(9'h08B, 8'h01);
    chk("pc warm", 32'h0, {19'h0, pc});
    xfer(9'h083, 1'b1, 8'hFF);
    wdog <= 1'b1;
    repeat (10) @(posedge clk);
    wdog <= 1'b0;
    repeat (10) @(posedge clk);
    rdchk(9'h083, 8'h0F);
    chk("status out", 32'h0F, {24'h0, status});
    $display("test warm done");
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    repeat (8) @(posedge clk);
    rdchk(9'h083, 8'h18);
    rdchk(9'h08E, 8'h02);
    chk("cause out", 32'h2, {30'h0, cause});
    rdchk(9'h084, 8'h00);
    $display("test cold done");
    stop_test();
  end
endmodule // test_sfr_bank1
